// ---- verilog/multispeed_program_sequencer.sv ----
// speed-program sequencer with stall gating and over-torque reaction select
// assumes an AXI4-Lite master, inputs synchronous to i_mclk, and a drive that
// reports ramp phase, output current, bus over-voltage and standstill
`timescale 1ns/1ps
module multispeed_program_sequencer
  import speed_program_pkg::*;
#(
  parameter int unsigned TICK_LEN = speed_program_pkg::TICK_CYCLES
) (
  // clock, reset, enable
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // AXI4-Lite slave
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // operator commands
  input  wire logic        i_run_cmd,
  input  wire logic        i_stop_cmd,
  input  wire logic        i_ext_fault,
  input  wire logic        i_estop,
  input  wire logic        i_ext_reverse,
  // drive feedback
  input  wire logic        i_accelerating,
  input  wire logic        i_decelerating,
  input  wire logic        i_at_speed,
  input  wire logic        i_output_stopped,
  input  wire logic        i_bus_overvolt,
  input  wire logic [15:0] i_out_current,
  input  wire logic        i_overtorque_det,
  // drive commands
  output logic             o_run,
  output logic             o_reverse,
  output logic [15:0]      o_freq_cmd,
  output logic [1:0]       o_ramp_set,
  output logic             o_ramp_hold,
  output logic             o_freq_reduce,
  output logic [15:0]      o_stall_decel_time,
  output logic             o_overtorque_alarm,
  output logic             o_overtorque_stop
);

  typedef struct packed {
    logic              aw_ok;
    logic [7:0]        aw_addr;
    logic              w_ok;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [15:0]       ctrl;
    logic [15:0]       dir_mask;
    logic [31:0]       ramp_sel;
    logic [23:0]       stall_lvl;
    logic [15:0]       stall_dt;
    logic [15:0]       rated_cur;
    logic [15:0][15:0] freq;
    logic [15:0][15:0] timer;
    seq_state_type     seq;
    logic [3:0]        step;
    logic [15:0]       elapsed;
    logic [22:0]       tick;
    logic              run;
    logic              rev;
    logic [15:0]       fcmd;
    logic [1:0]        ramp;
  } state_type;

  state_type q, d;

  // next non-zero timer step at or after 'from'; {found, wrapped, index}
  function automatic logic [5:0] seek(input logic [4:0] from, input logic [15:0][15:0] tm);
    logic [5:0] r;
    logic [4:0] s;
    r = 6'h00;
    for (int i = 0; i < 16; i++) begin
      s = 5'(from + 5'(i));
      if (!r[5] && tm[s[3:0]] != 16'h0000) begin
        r = {1'b1, s[4], s[3:0]};
      end
    end
    return r;
  endfunction : seek

  // current above a percent level, zero level disables
  function automatic logic over_lvl(input logic [7:0] lvl, input logic [15:0] cur,
                                    input logic [15:0] rated);
    return (lvl != 8'h00) &&
           (32'(cur) * 32'(PCT_FULL) > 32'(lvl) * 32'(rated));
  endfunction : over_lvl

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : merge

  // control fields
  logic [2:0]  sel;
  logic [1:0]  auto_mode;
  logic        retain;
  logic        ovs_en;
  logic [1:0]  ot_mode;
  logic        internal;
  logic        stop_evt;
  logic        step_done;
  logic [5:0]  nxt;
  logic [5:0]  first;
  logic [7:0]  mask8;
  logic [15:0] ramp16;
  logic [31:0] status;
  logic [31:0] rd_word;
  logic        rd_err;
  logic        wr_go;

  assign sel       = q.ctrl[CTRL_SEL_LSB +: 3];
  assign auto_mode = q.ctrl[CTRL_AUTO_LSB +: 2];
  assign retain    = q.ctrl[CTRL_RETAIN_BIT];
  assign ovs_en    = q.ctrl[CTRL_OVS_BIT];
  assign ot_mode   = q.ctrl[CTRL_OT_LSB +: 2];
  assign internal  = (sel == SEL_INTERNAL);
  // stall gating, levels are accel[7:0], const[15:8], decel[23:16]
  assign o_ramp_hold = (i_accelerating && over_lvl(q.stall_lvl[7:0], i_out_current,
                                                   q.rated_cur)) ||
                       (i_decelerating && ovs_en && i_bus_overvolt) ||
                       (i_decelerating && over_lvl(q.stall_lvl[23:16], i_out_current,
                                                   q.rated_cur));
  // lowering stops as soon as current is back, drive then ramps to o_freq_cmd
  assign o_freq_reduce = q.run && !i_accelerating && !i_decelerating &&
                         over_lvl(q.stall_lvl[15:8], i_out_current, q.rated_cur);
  assign o_stall_decel_time = q.stall_dt;
  // over-torque window: bit 1 widens to whole run, bit 0 asks for a stop
  assign o_overtorque_alarm = i_overtorque_det && q.run &&
                              (ot_mode[1] || i_at_speed);
  assign o_overtorque_stop  = o_overtorque_alarm && ot_mode[0];
  // only stop-type events reach a running program
  assign stop_evt  = i_stop_cmd || i_ext_fault || i_estop || o_overtorque_stop;
  assign step_done = internal && (q.tick == 23'(TICK_LEN - 1)) &&
                     (q.elapsed + 16'h0001 >= q.timer[q.step]);
  assign nxt   = seek(5'(q.step) + 5'h01, q.timer);
  assign first = seek(5'h00, q.timer);

  assign status = {9'h000, o_overtorque_alarm, o_freq_reduce, o_ramp_hold, q.ramp, q.rev,
                   q.run, 4'h0, q.seq, 4'h0, q.step};
  // register readback
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    if (s_axi_araddr >= OFS_TIMER_BASE && s_axi_araddr[1:0] == 2'b00) begin
      rd_word = {16'h0000, q.timer[s_axi_araddr[5:2]]};
    end else if (s_axi_araddr >= OFS_FREQ_BASE && s_axi_araddr < OFS_TIMER_BASE &&
                 s_axi_araddr[1:0] == 2'b00) begin
      rd_word = {16'h0000, q.freq[s_axi_araddr[5:2]]};
    end else begin
      unique case (s_axi_araddr)
        OFS_CTRL:      rd_word = {16'h0000, q.ctrl};
        OFS_DIR_MASK:  rd_word = {16'h0000, q.dir_mask};
        OFS_RAMP_SEL:  rd_word = q.ramp_sel;
        OFS_STALL_LVL: rd_word = {8'h00, q.stall_lvl};
        OFS_STALL_DT:  rd_word = {16'h0000, q.stall_dt};
        OFS_RATED_CUR: rd_word = {16'h0000, q.rated_cur};
        OFS_STATUS:    rd_word = status;
        default:       rd_err  = 1'b1;
      endcase
    end
  end
  // handshake outputs, low while frozen so no beat is taken and then lost
  assign s_axi_awready = i_ce && !q.aw_ok && !q.bvalid;
  assign s_axi_wready  = i_ce && !q.w_ok && !q.bvalid;
  assign s_axi_arready = i_ce && !q.rvalid;
  assign wr_go = q.aw_ok && q.w_ok && !q.bvalid;
  // next state
  always_comb begin
    logic [31:0] m;
    logic [7:0]  a;
    m = 32'h0000_0000;
    a = q.aw_addr;
    d = q;
    // write address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_ok   = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_ok   = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
    if (wr_go) begin
      d.aw_ok  = 1'b0;
      d.w_ok   = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      if (a >= OFS_TIMER_BASE && a[1:0] == 2'b00) begin
        m = merge({16'h0000, q.timer[a[5:2]]}, q.w_data, q.w_strb);
        d.timer[a[5:2]] = m[15:0];
      end else if (a >= OFS_FREQ_BASE && a < OFS_TIMER_BASE && a[1:0] == 2'b00) begin
        m = merge({16'h0000, q.freq[a[5:2]]}, q.w_data, q.w_strb);
        d.freq[a[5:2]] = m[15:0];
      end else begin
        unique case (a)
          OFS_CTRL: begin
            m = merge({16'h0000, q.ctrl}, q.w_data, q.w_strb);
            d.ctrl = m[15:0];
          end
          OFS_DIR_MASK: begin
            m = merge({16'h0000, q.dir_mask}, q.w_data, q.w_strb);
            d.dir_mask = m[15:0];
          end
          OFS_RAMP_SEL:  d.ramp_sel = merge(q.ramp_sel, q.w_data, q.w_strb);
          OFS_STALL_LVL: begin
            m = merge({8'h00, q.stall_lvl}, q.w_data, q.w_strb);
            d.stall_lvl = m[23:0];
          end
          OFS_STALL_DT: begin
            m = merge({16'h0000, q.stall_dt}, q.w_data, q.w_strb);
            d.stall_dt = m[15:0];
          end
          OFS_RATED_CUR: begin
            m = merge({16'h0000, q.rated_cur}, q.w_data, q.w_strb);
            d.rated_cur = m[15:0];
          end
          OFS_STATUS: d.bresp = RESP_OKAY; // read-only, write ignored
          default:    d.bresp = RESP_SLVERR;
        endcase
      end
    end
    // read channel
    if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_word;
      d.rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    // sequencer
    unique case (q.seq)
      ST_IDLE, ST_HOLD: begin
        if (i_run_cmd && !stop_evt) begin
          d.tick = 23'h000000;
          if (!internal) begin
            d.seq  = ST_RUN;
            d.step = 4'h0;
          end else if (q.seq == ST_HOLD) begin
            d.seq = ST_RUN;
          end else if (first[5]) begin
            d.seq     = ST_RUN;
            d.step    = first[3:0];
            d.elapsed = 16'h0000;
          end
        end
      end
      ST_RUN, ST_GAP: begin
        if (stop_evt) begin
          d.tick = 23'h000000;
          if (internal && retain) begin
            d.seq = ST_HOLD;
          end else begin
            d.seq     = ST_IDLE;
            d.step    = 4'h0;
            d.elapsed = 16'h0000;
          end
        end else if (q.seq == ST_GAP) begin
          if (i_output_stopped) d.seq = ST_RUN;
        end else if (internal) begin
          // external timing inputs have no path into this counter
          d.tick = (q.tick == 23'(TICK_LEN - 1)) ? 23'h000000 : q.tick + 23'h000001;
          if (q.tick == 23'(TICK_LEN - 1)) d.elapsed = q.elapsed + 16'h0001;
          if (step_done) begin
            d.elapsed = 16'h0000;
            if (!nxt[5] || (nxt[4] && !auto_mode[0])) begin
              d.seq  = ST_IDLE;
              d.step = 4'h0;
            end else begin
              d.step = nxt[3:0];
              d.seq  = auto_mode[1] ? ST_GAP : ST_RUN;
            end
          end
        end
      end
    endcase
    // drive command outputs follow the next state, second group uses upper halves
    d.run  = (d.seq == ST_RUN);
    d.fcmd = internal ? d.freq[d.step] : d.freq[0];
    mask8  = d.step[3] ? d.dir_mask[15:8] : d.dir_mask[7:0];
    ramp16 = d.step[3] ? d.ramp_sel[31:16] : d.ramp_sel[15:0];
    d.rev  = internal ? mask8[d.step[2:0]] : i_ext_reverse;
    d.ramp = internal ? ramp16[{d.step[2:0], 1'b0} +: 2] : 2'b00;
  end
  // state register, clock enable freezes everything
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      q           <= '0;
      q.ctrl      <= CTRL_RST;
      q.stall_lvl <= {STALL_DECEL_RST, STALL_CONST_RST, STALL_ACCEL_RST};
      q.stall_dt  <= STALL_DT_RST;
      q.rated_cur <= RATED_CUR_RST;
      q.freq      <= FREQ_RST;
      q.timer     <= TIMER_RST;
      q.seq       <= ST_IDLE;
    end else if (i_ce) begin
      q <= d;
    end
  end
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp  = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata  = q.rdata;
  assign s_axi_rresp  = q.rresp;
  assign o_run        = q.run;
  assign o_reverse    = q.rev;
  assign o_freq_cmd   = q.fcmd;
  assign o_ramp_set   = q.ramp;
  // checks
  sequence s_last_step_ends;
    i_ce && q.seq == ST_RUN && !stop_evt && step_done && nxt[5] && nxt[4];
  endsequence
  chk_halt_one_cycle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_last_step_ends and (!auto_mode[0]) |=> q.seq == ST_IDLE && !o_run)
    else $error("one-cycle program did not halt");
  chk_gap_between_steps: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && q.seq == ST_RUN && !stop_evt && step_done && nxt[5] && !nxt[4] && auto_mode[1])
    |=> q.seq == ST_GAP && !o_run)
    else $error("no stop between steps");
  chk_halt_stays: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (q.seq == ST_IDLE && !i_run_cmd) |=> q.seq == ST_IDLE)
    else $error("restart without run command");
  chk_retain_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && q.seq == ST_RUN && stop_evt && internal && retain)
    |=> q.seq == ST_HOLD && $stable(q.step) && $stable(q.elapsed))
    else $error("program state not retained");
  chk_fresh_stop: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && q.seq == ST_RUN && stop_evt && !retain) |=> q.seq == ST_IDLE && q.step == 4'h0)
    else $error("program not reset on stop");
  chk_ovs_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_decelerating && i_bus_overvolt && ovs_en) |-> o_ramp_hold)
    else $error("over-voltage did not hold ramp");
  chk_zero_lvl_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (q.stall_lvl[15:8] == 8'h00) |-> !o_freq_reduce)
    else $error("zero level still reduces");
  chk_ot_reaction: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_overtorque_stop |-> ot_mode[0] && (ot_mode[1] || i_at_speed))
    else $error("over-torque stop outside mode");
  chk_run_ignored: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && q.seq == ST_RUN && internal && !stop_evt && !step_done) |=> $stable(q.step))
    else $error("step moved without timer");
  chk_axi_bhold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule : multispeed_program_sequencer

// ---- verilog/speed_program_pkg.sv ----
// constants shared by the speed-program sequencer
// assumes a 40 MHz system clock and AXI4-Lite register access
package speed_program_pkg;
  // clock and timing
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned STEP_TICK_MS  = 100;   // step timers count in 0.1 s units
  localparam int unsigned TICK_CYCLES   = (STEP_TICK_MS * 1000 * 1000) / (CLK_PERIOD_PS / 1000);
  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_DIR_MASK  = 8'h04;
  localparam logic [7:0] OFS_RAMP_SEL  = 8'h08;
  localparam logic [7:0] OFS_STALL_LVL = 8'h0C;
  localparam logic [7:0] OFS_STALL_DT  = 8'h10;
  localparam logic [7:0] OFS_RATED_CUR = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;
  localparam logic [7:0] OFS_FREQ_BASE = 8'h40;  // 16 words, word 0 is main setpoint
  localparam logic [7:0] OFS_TIMER_BASE = 8'h80; // 16 words
  // control field positions
  localparam int unsigned CTRL_SEL_LSB    = 0;
  localparam int unsigned CTRL_AUTO_LSB   = 4;
  localparam int unsigned CTRL_RETAIN_BIT = 8;
  localparam int unsigned CTRL_OVS_BIT    = 9;
  localparam int unsigned CTRL_OT_LSB     = 12;
  // values after reset
  localparam logic [2:0]  SEL_NORMAL      = 3'h0;
  localparam logic [2:0]  SEL_INTERNAL    = 3'h1;
  localparam logic [15:0] CTRL_RST        = 16'h0200; // over-voltage stall on
  localparam logic [7:0]  STALL_ACCEL_RST = 8'h96;   // 150 %
  localparam logic [7:0]  STALL_CONST_RST = 8'h00;
  localparam logic [7:0]  STALL_DECEL_RST = 8'h96;   // 150 %
  localparam logic [15:0] STALL_DT_RST    = 16'h0032; // 5.0 s in 0.1 s
  localparam logic [15:0] RATED_CUR_RST   = 16'h0064;
  localparam logic [15:0] PCT_FULL        = 16'h0064; // 100 % = rated current
  localparam logic [15:0][15:0] FREQ_RST = {
    16'h1194, 16'h0FA0, 16'h0DAC, 16'h0BB8, 16'h09C4, 16'h07D0, 16'h05DC, 16'h03E8,
    16'h0032, 16'h0FA0, 16'h0DAC, 16'h0BB8, 16'h09C4, 16'h07D0, 16'h05DC, 16'h1388};
  localparam logic [15:0][15:0] TIMER_RST = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0064};
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN  = 4'b0010,
    ST_GAP  = 4'b0100,
    ST_HOLD = 4'b1000
  } seq_state_type;
endpackage : speed_program_pkg

// ---- tb/drive_stage_model.sv ----
// behavioural inverter stage: coarse frequency ramp toward the command
// assumes commands from the sequencer change on i_mclk rising edges
`timescale 1ns/1ps
module drive_stage_model (
  // clock
  input  wire logic        i_mclk,
  // commands from the sequencer
  input  wire logic        i_run,
  input  wire logic [15:0] i_freq_cmd,
  input  wire logic        i_ramp_hold,
  // drive state back to the sequencer
  output logic             o_accelerating,
  output logic             o_decelerating,
  output logic             o_at_speed,
  output logic             o_stopped
);
  logic [15:0] freq_q = 16'h0000;
  logic [15:0] target;

  // stopped drive ramps to zero; big steps keep step changes short
  assign target = i_run ? i_freq_cmd : 16'h0000;

  // a held ramp stays put, so stall flags never clear by themselves
  always @(posedge i_mclk) begin
    if (i_ramp_hold)
      freq_q <= freq_q;
    else if (target > freq_q)
      freq_q <= (target - freq_q > 16'h0100) ? freq_q + 16'h0100 : target;
    else
      freq_q <= (freq_q - target > 16'h0100) ? freq_q - 16'h0100 : target;
  end

  // ramp phase levels seen by the sequencer
  assign o_accelerating = freq_q < target;
  assign o_decelerating = freq_q > target;
  assign o_at_speed     = i_run && (freq_q == target);
  assign o_stopped      = freq_q == 16'h0000;
endmodule : drive_stage_model

// ---- tb/multispeed_program_sequencer_test.sv ----
// self-checking bench for the speed-program sequencer
// assumes TICK_LEN of 4 and the drive model on the far side
`timescale 1ns/1ps
module multispeed_program_sequencer_test;
  import speed_program_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [7:0]  aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0] w_d = 32'h0, r_d;
  logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  logic [1:0]  b_rs, r_rs, rset, cmd = 2'h0;
  logic        ext_rev = 1'b0, ovolt = 1'b0, otq = 1'b0;
  logic [15:0] cur = 16'h0000, fcmd, sdt;
  logic        acc, dec, spd, stp, run, rev, hold, reduce, ot_al, ot_st;
  int          errors = 0, checked = 0, cyc = 0;

  always #12.5 i_mclk = ~i_mclk;

  multispeed_program_sequencer #(.TICK_LEN(4)) dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_awaddr(aw_a),
    .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_bresp(b_rs),
    .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy), .s_axi_araddr(ar_a),
    .s_axi_rvalid(r_v), .s_axi_rready(r_r), .s_axi_rdata(r_d), .s_axi_rresp(r_rs),
    .i_run_cmd(cmd[0]), .i_stop_cmd(cmd[1]), .i_ext_fault(1'b0), .i_estop(1'b0),
    .i_ext_reverse(ext_rev), .i_accelerating(acc), .i_decelerating(dec),
    .i_at_speed(spd), .i_output_stopped(stp), .i_bus_overvolt(ovolt),
    .i_out_current(cur), .i_overtorque_det(otq),
    .o_run(run), .o_reverse(rev), .o_freq_cmd(fcmd), .o_ramp_set(rset),
    .o_ramp_hold(hold), .o_freq_reduce(reduce), .o_stall_decel_time(sdt),
    .o_overtorque_alarm(ot_al), .o_overtorque_stop(ot_st));

  drive_stage_model drive (
    .i_mclk(i_mclk), .i_run(run), .i_freq_cmd(fcmd), .i_ramp_hold(hold),
    .o_accelerating(acc), .o_decelerating(dec), .o_at_speed(spd), .o_stopped(stp));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // write and read hold valid until taken, ready until the answer
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    aw_a <= a;
    w_d  <= d;
    aw_v <= 1'b1;
    w_v  <= 1'b1;
    b_r  <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
    end while (b_v !== 1'b1);
    b_r <= 1'b0;
    chk(32'(b_rs), 32'(RESP_OKAY));
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge i_mclk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r  <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (ar_rdy) ar_v <= 1'b0;
    end while (r_v !== 1'b1);
    r_r <= 1'b0;
    chk(r_d, exp);
    chk(32'(r_rs), 32'(er));
  endtask : axr

  // command pulse: bit 0 run, bit 1 stop
  task automatic pulse(input logic [1:0] c);
    @(posedge i_mclk);
    cmd <= c;
    @(posedge i_mclk);
    cmd <= 2'h0;
  endtask : pulse

  task automatic until_run(input logic v);
    while (run !== v) @(negedge i_mclk);
  endtask : until_run

  task automatic set_cur(input logic [15:0] c);
    @(posedge i_mclk);
    cur <= c;
    @(negedge i_mclk);
  endtask : set_cur

  task automatic reset_values;
    axr(OFS_CTRL, 32'h0000_0200, RESP_OKAY);
    axr(OFS_DIR_MASK, 32'h0000_0000, RESP_OKAY);
    axr(OFS_STALL_LVL, 32'h0096_0096, RESP_OKAY);
    axr(OFS_STALL_DT, 32'h0000_0032, RESP_OKAY);
    axr(8'h3C, 32'h0000_0000, RESP_SLVERR);
  endtask : reset_values

  // one cycle with stops between steps, external reverse held high
  task automatic one_cycle_program;
    int n;
    logic hi;
    axw(OFS_DIR_MASK, 32'hFFFF_FF02);
    axr(OFS_DIR_MASK, 32'h0000_FF02, RESP_OKAY);
    axw(OFS_RAMP_SEL, 32'h0000_0007);
    axw(OFS_CTRL, 32'h0000_0221);
    ext_rev <= 1'b1;
    pulse(2'h1);
    until_run(1'b1);
    chk(32'(fcmd), 32'(FREQ_RST[0]));
    chk(32'(rev), 32'h0);
    chk(32'(rset), 32'h3);
    n = 0;
    while (run === 1'b1) begin
      @(negedge i_mclk);
      n++;
    end
    chk(n, 32'(TIMER_RST[0]) * 32'h4);
    until_run(1'b1);
    chk(32'(fcmd), 32'(FREQ_RST[1]));
    chk(32'(rev), 32'h1);
    chk(32'(rset), 32'h1);
    until_run(1'b0);
    hi = 1'b0;
    repeat (60) begin
      @(negedge i_mclk);
      if (run !== 1'b0) hi = 1'b1;
    end
    chk(32'(hi), 32'h0);
    pulse(2'h1);
    ext_rev <= 1'b0;
    until_run(1'b1);
    chk(32'(fcmd), 32'(FREQ_RST[0]));
    pulse(2'h2);
    repeat (3) @(negedge i_mclk);
    chk(32'(run), 32'h0);
  endtask : one_cycle_program

  // stop inside the second step with retain on, a new run resumes that step
  task automatic retain_resume;
    axw(OFS_CTRL, 32'h0000_0301);
    pulse(2'h1);
    until_run(1'b1);
    repeat (450) @(negedge i_mclk);
    chk(32'(fcmd), 32'(FREQ_RST[1]));
    pulse(2'h2);
    pulse(2'h1);
    until_run(1'b1);
    chk(32'(fcmd), 32'(FREQ_RST[1]));
    pulse(2'h2);
  endtask : retain_resume

  task automatic stall_gating;
    axw(OFS_DIR_MASK, 32'h0000_00FF);
    axw(OFS_CTRL, 32'h0000_3200);
    pulse(2'h1);
    until_run(1'b1);
    chk(32'(rev), 32'h0);
    set_cur(16'h0097);
    chk(32'(hold), 32'h1);
    set_cur(16'h0096);
    chk(32'(hold), 32'h0);
    while (spd !== 1'b1) @(negedge i_mclk);
    set_cur(16'h00FA);
    chk(32'(reduce), 32'h0);
    axw(OFS_STALL_LVL, 32'h0096_6496);
    @(negedge i_mclk);
    chk(32'(reduce), 32'h1);
    chk(32'(sdt), 32'h32);
    set_cur(16'h0064);
    chk(32'(reduce), 32'h0);
    pulse(2'h2);
    while (dec !== 1'b1) @(negedge i_mclk);
    @(posedge i_mclk);
    ovolt <= 1'b1;
    @(negedge i_mclk);
    chk(32'(hold), 32'h1);
    @(posedge i_mclk);
    ovolt <= 1'b0;
    set_cur(16'h0097);
    chk(32'(hold), 32'h1);
    set_cur(16'h0000);
  endtask : stall_gating

  // every over-torque mode once, detector raised while ramping and again at speed
  task automatic overtorque_modes;
    for (int m = 0; m < 4; m++) begin
      axw(OFS_CTRL, 32'h0000_0200 | (32'(m) << 12));
      pulse(2'h1);
      until_run(1'b1);
      @(posedge i_mclk);
      otq <= 1'b1;
      @(negedge i_mclk);
      chk(32'(ot_al), 32'(m[1]));
      chk(32'(ot_st), 32'(m == 3));
      @(posedge i_mclk);
      otq <= 1'b0;
      if (m == 3) pulse(2'h1);
      while (spd !== 1'b1) @(negedge i_mclk);
      @(posedge i_mclk);
      otq <= 1'b1;
      @(negedge i_mclk);
      chk(32'(ot_al), 32'h1);
      chk(32'(ot_st), 32'(m[0]));
      @(posedge i_mclk);
      otq <= 1'b0;
      pulse(2'h2);
      until_run(1'b0);
    end
  endtask : overtorque_modes

  task automatic give_verdict;
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // hang guard, well above the fewer than two thousand cycles the run needs
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict;
    end
  end

  initial begin
    repeat (5) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    reset_values;
    one_cycle_program;
    retain_resume;
    stall_gating;
    overtorque_modes;
    give_verdict;
  end
endmodule : multispeed_program_sequencer_test
